// ==== verilog/adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;

  // trigger select codes
  typedef enum logic [1:0] {
    TRIG_SOFTWARE = 2'h0,
    TRIG_TIMER3   = 2'h1,
    TRIG_PIN_EDGE = 2'h2,
    TRIG_TIMER2   = 2'h3
  } trig_sel_t;

  // control bit positions
  localparam int unsigned BUSY_BIT   = 4;
  localparam int unsigned TRIG_LO    = 2;
  localparam int unsigned WIN_BIT    = 1;
  localparam int unsigned JUST_BIT   = 0;

  localparam int unsigned RES_W      = 10;
  localparam int unsigned LJ_PAD_W   = 6;

  // reset values
  localparam logic        BUSY_RST   = 1'b0;
  localparam logic        WIN_RST    = 1'b0;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // result byte pair as seen by software
  typedef struct packed {
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
  } result_pair_t;

  // converter handshake toward the analog core
  typedef struct packed {
    logic              start;
    logic [RES_W-1:0]  unused_pad;
  } conv_req_t;

endpackage

// ==== verilog/adc_conversion_control.sv ====
`timescale 1ns/1ps
// Functional notes
// - busy flag reads one throughout a conversion
// - busy reads zero after finish and after reset
// - busy falling edge raises completion interrupt when enabled
// - software write of one starts conversion only in code 00
// - trigger select occupies bits 3-2; 00 is software start
// - code 01 starts conversion on each Timer 3 overflow
// - code 10 starts on each rising edge of external pin
// - code 11 starts conversion on each Timer 2 overflow
// - window match flag sets on match, holds until cleared
// - justify bit zero places result right justified
module adc_conversion_control (
  // clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_arst_n,
  // software control
  input  wire logic                        i_busy_wr,
  input  wire logic                        i_busy_wdata,
  input  wire adc_ctrl_pkg::trig_sel_t     i_start_trigger_select,
  input  wire logic                        i_justify_select_bit,
  input  wire logic                        i_win_clr,
  input  wire logic                        i_eoc_int_en,
  // trigger sources
  input  wire logic                        i_timer3_ovf,
  input  wire logic                        i_timer2_ovf,
  input  wire logic                        i_external_convert_pin,
  // analog converter
  input  wire logic                        i_conv_done,
  input  wire logic [9:0]                  i_conv_result,
  input  wire logic                        i_window_match,
  output logic                             o_conv_start,
  // status and result
  output logic                             o_conversion_busy_flag,
  output logic                             o_window_match_flag,
  output logic                             o_eoc_irq,
  output adc_ctrl_pkg::result_pair_t       o_result
);
  import adc_ctrl_pkg::*;

  // pick the active start source; every source funnels through one
  // decode so a new code cannot be wired in one place and missed elsewhere
  function automatic logic trig_fire(
    input trig_sel_t sel,
    input logic      sw_req,
    input logic      t3_req,
    input logic      pin_req,
    input logic      t2_req
  );
    logic fire;
    fire = 1'b0;
    unique case (sel)
      TRIG_SOFTWARE: fire = sw_req;
      TRIG_TIMER3:   fire = t3_req;
      TRIG_PIN_EDGE: fire = pin_req;
      TRIG_TIMER2:   fire = t2_req;
    endcase
    return fire;
  endfunction

  // place the ten-bit word in the byte pair; the spare bits are zero so
  // software may read either byte alone without masking
  // left justified pads the low six bits, right justified the high six
  function automatic result_pair_t place_result(
    input logic             left,
    input logic [RES_W-1:0] raw
  );
    result_pair_t pair;
    if (left) begin
      pair = {raw, {LJ_PAD_W{1'b0}}};
    end else begin
      pair = {{LJ_PAD_W{1'b0}}, raw};
    end
    return pair;
  endfunction

  // pin synchroniser and edge detector
  logic                pin_s1_q;
  logic                pin_s2_q;
  logic                pin_prev_q;
  logic                pin_rise;

  // start path
  logic                sw_req;
  logic                trig_hit;
  logic                start_go;

  // conversion state
  logic                busy_q;
  logic                busy_d;
  logic                done_seen;
  logic                busy_fall;

  // window match flag
  logic                win_q;
  logic                win_d;

  // completion interrupt
  logic                irq_q;
  logic                irq_d;

  // captured word and its formatted view
  logic [RES_W-1:0]    raw_q;
  logic [RES_W-1:0]    raw_d;
  result_pair_t        res_q;
  result_pair_t        res_d;

  // two flops before any logic reads the pin; the edge detector resets to
  // the pin's idle low level so no false edge follows reset
  // trade-off: pin pulses shorter than a clock period may be missed
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_q   <= 1'b0;
      pin_s2_q   <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= i_external_convert_pin;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // a rising edge costs two cycles of latency through the synchroniser
  assign pin_rise = pin_s2_q & ~pin_prev_q;

  // a write of zero never reaches the decode, so it has no effect
  assign sw_req   = i_busy_wr & i_busy_wdata;

  // trigger selection; a start while busy is ignored so a run is never cut
  assign trig_hit = trig_fire(i_start_trigger_select, sw_req,
                              i_timer3_ovf, pin_rise, i_timer2_ovf);
  assign start_go = trig_hit & ~busy_q;

  // limitation: a trigger that lands while busy is lost, not queued;
  // software needing every trigger must pace them slower than a run
  // the converter sees the start in the same cycle it is accepted
  assign o_conv_start = start_go;

  // done only counts while a run is open; a stray pulse is dropped
  assign done_seen = busy_q & i_conv_done;

  // busy: set on start, held until done, cleared on done
  assign busy_d = start_go ? 1'b1 : (done_seen ? 1'b0 : busy_q);

  // the falling edge of busy is what completes a run
  assign busy_fall = busy_q & ~busy_d;

  // the enable gates the pulse, not the edge, so a late enable never
  // raises an interrupt for a run that ended earlier
  assign irq_d = busy_fall & i_eoc_int_en;

  // a match sets and wins over a same-cycle clear so no event is lost;
  // only the clear input lowers the flag
  assign win_d = i_window_match ? 1'b1 : (i_win_clr ? 1'b0 : win_q);

  // keep the last word until the next run finishes
  assign raw_d = done_seen ? i_conv_result : raw_q;

  // justification is applied on output so toggling it reformats old data
  assign res_d = place_result(i_justify_select_bit, raw_q);

  // busy register; zero after reset as no valid word exists yet
  // a start and a done cannot meet here since a start needs busy low
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_q <= BUSY_RST;
    end else begin
      busy_q <= busy_d;
    end
  end

  // window match flag register
  // software owns the clear; hardware never lowers the flag by itself
  // a clear pulse while no match is pending is harmless
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      win_q <= WIN_RST;
    end else begin
      win_q <= win_d;
    end
  end

  // completion pulse lasts one cycle because busy falls once per run
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // result word register; the word is taken only on an accepted done so
  // the pair never shows a half-finished conversion
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      raw_q <= RESULT_RST[RES_W-1:0];
    end else begin
      raw_q <= raw_d;
    end
  end

  // formatted result register, so the bytes never glitch on a mode change
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      res_q <= RESULT_RST;
    end else begin
      res_q <= res_d;
    end
  end

  // status outputs come straight from their flip-flops
  assign o_conversion_busy_flag = busy_q;
  assign o_window_match_flag    = win_q;
  assign o_eoc_irq              = irq_q;
  assign o_result               = res_q;

endmodule

// ==== verification/adc_conversion_control_props.sv ====
`timescale 1ns/1ps
module adc_conversion_control_props import adc_ctrl_pkg::*; (
  input wire logic i_sys_clk, i_arst_n, i_busy_wr, i_busy_wdata,
  input wire trig_sel_t i_start_trigger_select,
  input wire logic i_justify_select_bit, i_win_clr, i_eoc_int_en,
  input wire logic i_timer3_ovf, i_timer2_ovf, i_external_convert_pin,
  input wire logic i_conv_done, i_window_match, o_conv_start,
  input wire logic [9:0] i_conv_result,
  input wire logic o_conversion_busy_flag, o_window_match_flag, o_eoc_irq,
  input wire result_pair_t o_result);
  wire       b = o_conversion_busy_flag;
  wire [1:0] s = i_start_trigger_select;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // starts only count while idle, so busy gates every source
  property p_sw;
    !b && s == 2'h0 && i_busy_wr && i_busy_wdata |-> o_conv_start;
  endproperty
  a_sw: assert property (p_sw) else $error("sw start");
  property p_t3; !b && s == 2'h1 && i_timer3_ovf |-> o_conv_start; endproperty
  a_t3: assert property (p_t3) else $error("t3 start");
  property p_set; o_conv_start |=> b; endproperty
  a_set: assert property (p_set) else $error("busy set");
  property p_hold; b && !i_conv_done |=> b; endproperty
  a_hold: assert property (p_hold) else $error("busy hold");
  property p_fall; b && i_conv_done |=> !b; endproperty
  a_fall: assert property (p_fall) else $error("busy fall");
  property p_irq;
    b && i_conv_done && i_eoc_int_en |=> o_eoc_irq ##1 !o_eoc_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_win; i_window_match |=> o_window_match_flag; endproperty
  a_win: assert property (p_win) else $error("win set");
  property p_keep; o_window_match_flag && !i_win_clr |=> o_window_match_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("win kept");
  // main scenarios
  c_irq: cover property (o_eoc_irq);
  c_done: cover property (b && i_conv_done);
  c_clr: cover property (o_window_match_flag && i_win_clr);
endmodule
bind adc_conversion_control adc_conversion_control_props
  u_adc_conversion_control_props (.*);

// ==== verification/adc_conversion_control_bench.sv ====
`timescale 1ns/1ps
module adc_conversion_control_bench;
  import adc_ctrl_pkg::*;
  logic i_sys_clk = 0, i_arst_n = 0, i_busy_wr = 0, i_busy_wdata = 0;
  logic i_justify_select_bit = 0, i_win_clr = 0, i_eoc_int_en = 1;
  logic i_timer3_ovf = 0, i_timer2_ovf = 0, i_external_convert_pin = 0;
  logic i_conv_done = 0, i_window_match = 0, o_conv_start, o_eoc_irq;
  logic o_conversion_busy_flag, o_window_match_flag;
  logic [9:0] i_conv_result = 0;
  trig_sel_t i_start_trigger_select = TRIG_SOFTWARE;
  result_pair_t o_result;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  adc_conversion_control u_adc_conversion_control (.*);
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  // hang guard, far above the roughly one hundred cycles used
  always @(posedge i_sys_clk) if (++cyc == 3000) begin
    fail_count++;
    complete_run();
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // src 0 write one, 1 timer3, 2 pin, 3 timer2, 4 write zero
  task automatic conv(trig_sel_t c, int src, logic j, logic [9:0] r, logic go);
    @(posedge i_sys_clk);
    i_start_trigger_select <= c;
    i_justify_select_bit <= j;
    i_busy_wdata <= src != 4;
    @(posedge i_sys_clk);
    {i_busy_wr, i_timer3_ovf, i_external_convert_pin, i_timer2_ovf} <=
      (src == 4) ? 4'h8 : 4'h8 >> src;
    @(posedge i_sys_clk);
    {i_busy_wr, i_timer3_ovf, i_external_convert_pin, i_timer2_ovf} <= 4'h0;
    repeat (3) @(posedge i_sys_clk);
    #1 chk("busy", go, o_conversion_busy_flag);
    @(posedge i_sys_clk);
    i_conv_done <= go;
    i_conv_result <= r;
    @(posedge i_sys_clk);
    i_conv_done <= 0;
    #1 chk("idle", 0, o_conversion_busy_flag);
    chk("irq", go & i_eoc_int_en, o_eoc_irq);
    repeat (2) @(posedge i_sys_clk);
    #1 if (go) chk("res", j ? {r, 6'h00} : {6'h00, r}, o_result);
    $display("test %0d %0d done", c, src);
  endtask
  task automatic complete_run();
    $display("checked %0d wrong %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_arst_n <= 1;
    #1 chk("busy", 0, o_conversion_busy_flag);
    chk("win", 0, o_window_match_flag);
    conv(TRIG_SOFTWARE, 0, 0, 10'h3FF, 1);
    conv(TRIG_TIMER3, 1, 1, 10'h201, 1);
    conv(TRIG_PIN_EDGE, 2, 0, 10'h155, 1);
    conv(TRIG_TIMER2, 3, 1, 10'h0AA, 1);
    conv(TRIG_TIMER3, 0, 0, 10'h000, 0);
    conv(TRIG_SOFTWARE, 4, 0, 10'h000, 0);
    conv(TRIG_SOFTWARE, 1, 0, 10'h000, 0);
    @(posedge i_sys_clk) i_eoc_int_en <= 0;
    conv(TRIG_SOFTWARE, 0, 1, 10'h2C3, 1);
    @(posedge i_sys_clk) i_window_match <= 1;
    @(posedge i_sys_clk) i_window_match <= 0;
    repeat (4) @(posedge i_sys_clk);
    #1 chk("win", 1, o_window_match_flag);
    @(posedge i_sys_clk) i_win_clr <= 1;
    @(posedge i_sys_clk) i_win_clr <= 0;
    #1 chk("win", 0, o_window_match_flag);
    $display("test window done");
    complete_run();
  end
endmodule
